// file: rtl/adr_consts.vh
// Constants for the amplifier diagnostic reporting block.
`ifndef ADR_CONSTS_VH
`define ADR_CONSTS_VH
// =============================================================
// Clock and timing
`define ADR_CLK_MHZ            250
`define ADR_DET_TIME_US        2000
`define ADR_HOLD_TIME_MS       50
`define ADR_DET_CYCLES         (`ADR_DET_TIME_US * `ADR_CLK_MHZ)
`define ADR_HOLD_CYCLES        (`ADR_HOLD_TIME_MS * 1000 * `ADR_CLK_MHZ)
// =============================================================
// Instruction byte fields
`define ADR_IB1_STANDBY_N      0
`define ADR_IB1_CH_DIS         1
`define ADR_IB1_NO_CLIP        5
`define ADR_IB1_NO_OFFS        7
`define ADR_IB2_CH_DIS         1
`define ADR_IB2_DCDET_EN       2
`define ADR_IB2_NO_WARN        4
`define ADR_IB2_NO_CLIP        5
`define ADR_IB3_ACDET_EN       4
`define ADR_IB_RESET           8'h00
// =============================================================
// Result byte fields
`define ADR_DB_OFFSET          2
`define ADR_DB_SHORT           3
`define ADR_DB_OPEN            4
`define ADR_DB_VALID           6
`define ADR_DB_RESET           8'h00
`endif

// file: rtl/adr_fault_report_pin.v
// Fault flag pins, latched result bytes and load-detect sequencing for an amplifier.
//
// Function
// (RULE_01) Fault and saturation pins are open drain: pull low when asserted, float otherwise.
// (RULE_02) Fault pin goes low on any output short, overcurrent or window trip.
// (RULE_03) Short status bits latch, survive removal, clear when read.
// (RULE_04) One read returns old latched faults; two reads give the current status.
// (RULE_05) Fault pin releases at once when the fault clears, whatever the latches.
// (RULE_06) Host mode: fault pin shows POR, supply, short, heat; offset selectable.
// (RULE_07) Pin mode: both pins report every source they carry, without selection.
// (RULE_08) DC load detection works only in host mode, enabled by instruction bit two-two.
// (RULE_09) DC detection runs before switching starts and lengthens standby-to-mute.
// (RULE_10) Open-load result in bit four of each result byte.
// (RULE_11) Shorted loads in bit three, checked only once operating after detection.
// (RULE_12) DC detection counts a shorted speaker as a speaker load.
// (RULE_13) Valid bit six set after a completed detection; results valid only then.
// (RULE_14) Valid bit cleared on supply fault during detection or on hang-up.
// (RULE_15) Host writes detection enable back to zero after each cycle.
// (RULE_16) Toggling detection enable reruns detection while no channel is enabled.
// (RULE_17) Host bounds detection retries with its own counter and limit.
// (RULE_18) AC load detection in host mode, bit four of byte three, flags saturation pin.
// (RULE_19) Host applies a suitable test tone for AC load detection.
// (RULE_20) Clip flags the saturation pin for channels whose clip-disable bit is zero.
// (RULE_21) Switch-off mutes first, then discharges the ripple ramp capacitor.
// (RULE_22) Slave goes off after discharge; master holds its clock about 50 ms more.
// (RULE_23) An external clock must keep running during the shutdown delay.
// (RULE_24) Offset sets result bit two; fault pin shows it only if selected.
// (RULE_25) Detection time and clock hold are cycle counts from the clock rate.
//
// Timing: every pin and guard input passes a two-stage synchroniser, so a change
// reaches the flag pins and the result bytes three clock edges after it happens.
// The instruction bytes and the read strobe come from logic on this clock and
// are used as they stand.
//
// The flag pins have no memory of their own: they follow the live fault sources,
// while the result bytes keep what happened until the host reads them.
//
// The host bounds its detection retries itself; the block only re-arms a run
// when the enable bit has been low with both channels disabled.
//
// Limitation: the detection and hold times are plain cycle counts, so they scale
// with the clock and must be set again if the oscillator rate changes.

`include "adr_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module adr_fault_report_pin #(
    parameter integer DET_CYCLES  = `ADR_DET_CYCLES,
    parameter integer HOLD_CYCLES = `ADR_HOLD_CYCLES
) (
    input  wire       sys_clk,
    input  wire       arst_n,
    input  wire       clk_en,
    input  wire       host_mode,
    input  wire       master_mode,
    input  wire [7:0] instr_byte_one,
    input  wire [7:0] instr_byte_two,
    input  wire [7:0] instr_byte_three,
    input  wire       result_read,
    input  wire       power_up_pin,
    input  wire       por_event,
    input  wire       undervoltage_guard,
    input  wire       overvoltage_guard,
    input  wire [1:0] overcurrent_guard,
    input  wire [1:0] window_guard,
    input  wire       overtemp_guard,
    input  wire       offset_guard,
    input  wire [1:0] clip_detect,
    input  wire       temp_warning,
    input  wire       ac_current_over,
    input  wire [1:0] open_load_sense,
    input  wire       ramp_discharged,
    input  wire       amp_hang,
    output reg  [7:0] result_byte_one,
    output reg  [7:0] result_byte_two,
    output reg        fault_report_pin_o,
    output reg        fault_report_pin_oe,
    output reg        saturation_flag_pin_o,
    output reg        saturation_flag_pin_oe,
    output reg        detect_busy,
    output reg        switching_en,
    output reg        mute_req,
    output reg        ramp_discharge,
    output reg        osc_run
);

// =============================================================
// Input synchronisers
// All fault inputs come from analog comparators outside the clock domain.
localparam integer NSYNC = 20;
wire [NSYNC-1:0] async_in;
reg  [NSYNC-1:0] sync1_reg;
reg  [NSYNC-1:0] sync2_reg;

// Order matters: the slices below pick the synchronised copies by position.
assign async_in = {power_up_pin,
                   por_event,
                   undervoltage_guard,
                   overvoltage_guard,
                   overcurrent_guard,
                   window_guard,
                   overtemp_guard,
                   offset_guard,
                   clip_detect,
                   temp_warning,
                   ac_current_over,
                   open_load_sense,
                   ramp_discharged,
                   amp_hang,
                   host_mode,
                   master_mode};

always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        sync1_reg <= {NSYNC{1'b0}};
        sync2_reg <= {NSYNC{1'b0}};
    end else if (clk_en) begin
        sync1_reg <= async_in;
        sync2_reg <= sync1_reg;
    end
end

wire       s_pwr    = sync2_reg[19];
wire       s_por    = sync2_reg[18];
wire       s_uv     = sync2_reg[17];
wire       s_ov     = sync2_reg[16];
wire [1:0] s_oc     = sync2_reg[15:14];
wire [1:0] s_win    = sync2_reg[13:12];
wire       s_ot     = sync2_reg[11];
wire       s_offs   = sync2_reg[10];
wire [1:0] s_clip   = sync2_reg[9:8];
wire       s_warn   = sync2_reg[7];
wire       s_ac     = sync2_reg[6];
wire [1:0] s_open   = sync2_reg[5:4];
wire       s_disch  = sync2_reg[3];
wire       s_hang   = sync2_reg[2];
wire       s_host   = sync2_reg[1];
wire       s_master = sync2_reg[0];

// =============================================================
// Sequencer
localparam [2:0] ST_OFF    = 3'h0;
localparam [2:0] ST_DETECT = 3'h1;
localparam [2:0] ST_MUTE   = 3'h2;
localparam [2:0] ST_OPER   = 3'h3;
localparam [2:0] ST_MUTEDN = 3'h4;
localparam [2:0] ST_DISCH  = 3'h5;
localparam [2:0] ST_HOLD   = 3'h6;

reg [2:0]  state_reg;
reg [2:0]  state_next;
reg [31:0] cnt_reg;
reg [31:0] cnt_next;
reg        det_arm_reg;
reg        det_done;
reg        det_abort;

wire supply_fault = s_uv | s_ov;
wire run_req      = s_pwr & instr_byte_one[`ADR_IB1_STANDBY_N];
wire det_en       = s_host & instr_byte_two[`ADR_IB2_DCDET_EN];              // [RULE_08]
wire chans_off    = instr_byte_one[`ADR_IB1_CH_DIS] & instr_byte_two[`ADR_IB2_CH_DIS];

// One counter serves both the detection time and the master clock hold, since
// the two never run at the same time.
always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    det_done   = 1'b0;
    det_abort  = 1'b0;
    case (state_reg)

        // Standby. With both channels disabled the amplifier stays here between
        // detection runs, so a host retry loop never starts the output stage.
        ST_OFF: begin
            if (run_req && det_en && det_arm_reg) begin                     // [RULE_09]
                state_next = ST_DETECT;
                cnt_next   = 32'h0000_0000;
            end else if (run_req && !det_en && !chans_off) begin            // [RULE_16]
                state_next = ST_MUTE;
            end
        end

        // Load test pulse; a supply trip or a hang-up throws the run away.
        ST_DETECT: begin
            if (supply_fault || s_hang || !run_req) begin
                det_abort  = 1'b1;                                          // [RULE_14]
                state_next = ST_OFF;
            end else if (cnt_reg >= DET_CYCLES - 1) begin                   // [RULE_25]
                det_done   = 1'b1;
                state_next = ST_MUTE;
            end else begin
                cnt_next = cnt_reg + 32'h0000_0001;
            end
        end

        // Output stage switching but muted; the mute bit picks play or mute.
        ST_MUTE: begin
            if (!run_req) begin
                state_next = ST_MUTEDN;
            end else if (!instr_byte_two[0]) begin
                state_next = ST_OPER;
            end
        end

        // Playing. Short status bits may only be latched in this state.
        ST_OPER: begin
            if (!run_req || instr_byte_two[0]) begin
                state_next = ST_MUTEDN;
            end
        end

        // One cycle of mute before deciding to stop or to resume.
        ST_MUTEDN: begin
            if (run_req && !instr_byte_two[0]) begin
                state_next = ST_OPER;
            end else if (!run_req) begin
                state_next = ST_DISCH;                                      // [RULE_21]
            end else begin
                state_next = ST_MUTE;
            end
        end

        // Wait for the ramp capacitor to be empty before leaving.
        ST_DISCH: begin
            if (s_disch) begin
                cnt_next   = 32'h0000_0000;
                state_next = s_master ? ST_HOLD : ST_OFF;                   // [RULE_22]
            end
        end

        // Master only: keep the clock alive so the slaves can shut down.
        ST_HOLD: begin
            if (cnt_reg >= HOLD_CYCLES - 1) begin                           // [RULE_25]
                state_next = ST_OFF;
            end else begin
                cnt_next = cnt_reg + 32'h0000_0001;
            end
        end

        default: state_next = ST_OFF;
    endcase
end

always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        state_reg   <= ST_OFF;
        cnt_reg     <= 32'h0000_0000;
        det_arm_reg <= 1'b1;
    end else if (clk_en) begin
        state_reg <= state_next;
        cnt_reg   <= cnt_next;
        // One detection per enable; a low enable re-arms, only with channels off.
        if (!det_en && chans_off)
            det_arm_reg <= 1'b1;                                            // [RULE_16]
        else if (state_reg == ST_DETECT)
            det_arm_reg <= 1'b0;
    end
end

// =============================================================
// Result bytes and flag pins
// Latched bits: hardware set wins over the read clear in the same cycle.
// A short that is still present during a read therefore shows again on the
// next read, which is how the host tells an old fault from a current one.
// The read clears only the short and offset bits; the open-load results stand
// until the next run completes, and the valid bit until the next run starts, aborts or hangs.
// The flag pins are registered so that every output comes from a flip-flop;
// this costs one cycle of latency against the live fault sources.
wire        operating = (state_reg == ST_OPER);
wire        offs_sel  = !s_host || !instr_byte_one[`ADR_IB1_NO_OFFS];
wire        clip_any  = (s_clip[0] & (!s_host | !instr_byte_one[`ADR_IB1_NO_CLIP])) |
                        (s_clip[1] & (!s_host | !instr_byte_two[`ADR_IB2_NO_CLIP]));   // [RULE_20]
wire        warn_sel  = s_warn & (!s_host | !instr_byte_two[`ADR_IB2_NO_WARN]);
wire        ac_flag   = s_host & instr_byte_three[`ADR_IB3_ACDET_EN] & s_ac;  // [RULE_18]
wire        fault_now = s_por | supply_fault | (|s_oc) | (|s_win) | s_ot |
                        (s_offs & offs_sel);                                // [RULE_02] [RULE_06] [RULE_07] [RULE_24]
wire        sat_now   = s_por | clip_any | warn_sel | ac_flag;              // [RULE_06] [RULE_07]
wire [1:0]  short_set = operating ? (s_oc | s_win) : 2'b00;                 // [RULE_11]
wire [7:0]  rb1_clr   = result_read ? 8'h0c : 8'h00;
wire [7:0]  rb2_clr   = result_read ? 8'h08 : 8'h00;
wire [7:0]  rb1_set;
wire [7:0]  rb2_set;

assign rb1_set = {1'b0, 1'b0, 1'b0, 1'b0, short_set[0], s_host & s_offs, 2'b00};
assign rb2_set = {1'b0, 1'b0, 1'b0, 1'b0, short_set[1], 3'b000};

always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
        result_byte_one        <= `ADR_DB_RESET;
        result_byte_two        <= `ADR_DB_RESET;
        fault_report_pin_o     <= 1'b0;
        fault_report_pin_oe    <= 1'b0;
        saturation_flag_pin_o  <= 1'b0;
        saturation_flag_pin_oe <= 1'b0;
        detect_busy            <= 1'b0;
        switching_en           <= 1'b0;
        mute_req               <= 1'b1;
        ramp_discharge         <= 1'b0;
        osc_run                <= 1'b0;
    end else if (clk_en) begin
        result_byte_one <= (result_byte_one & ~rb1_clr) | rb1_set;          // [RULE_03] [RULE_04]
        result_byte_two <= (result_byte_two & ~rb2_clr) | rb2_set;          // [RULE_03]
        if (det_done) begin
            // A shorted speaker shows as a speaker load: open bit stays zero.
            result_byte_one[`ADR_DB_OPEN]  <= s_open[0];                    // [RULE_10] [RULE_12]
            result_byte_two[`ADR_DB_OPEN]  <= s_open[1];                    // [RULE_10]
            result_byte_one[`ADR_DB_VALID] <= 1'b1;                         // [RULE_13]
        end else if (det_abort || (s_hang && state_reg != ST_OFF) ||
                     state_next == ST_DETECT) begin
            result_byte_one[`ADR_DB_VALID] <= 1'b0;                         // [RULE_14]
        end

        // Open drain: the data bit stays low and only the enable moves.
        fault_report_pin_o     <= 1'b0;
        fault_report_pin_oe    <= fault_now;                                // [RULE_01] [RULE_05]
        saturation_flag_pin_o  <= 1'b0;
        saturation_flag_pin_oe <= sat_now;                                  // [RULE_01]

        // Status levels are taken from the next state so they line up with it.
        detect_busy            <= (state_next == ST_DETECT);
        switching_en           <= (state_next == ST_MUTE) || (state_next == ST_OPER) ||
                                  (state_next == ST_MUTEDN);
        mute_req               <= (state_next != ST_OPER);                  // [RULE_21]
        ramp_discharge         <= (state_next == ST_DISCH);
        osc_run                <= (state_next != ST_OFF) && (state_next != ST_HOLD || s_master); // [RULE_22]
    end
end

endmodule
`default_nettype wire

// file: dv/adr_fault_report_pin_properties.sv
// Concurrent checks on the ports of the amplifier diagnostic block.
`timescale 1ns/1ps
`default_nettype none
module adr_fault_report_pin_props #(
    parameter integer DET_CYCLES  = 20,
    parameter integer HOLD_CYCLES = 40
) (
    input wire logic       sys_clk, arst_n, clk_en, host_mode, master_mode, result_read,
    input wire logic       por_event, undervoltage_guard, overvoltage_guard, overtemp_guard, offset_guard,
    input wire logic [1:0] overcurrent_guard, window_guard, clip_detect,
    input wire logic [7:0] instr_byte_one, result_byte_one, result_byte_two,
    input wire logic       fault_report_pin_o, fault_report_pin_oe, saturation_flag_pin_o, saturation_flag_pin_oe,
    input wire logic       detect_busy, switching_en, mute_req, ramp_discharge, osc_run
);
    // ==========
    // Helper logic
    logic [31:0] busy_cnt;
    wire logic   any_fault = por_event | undervoltage_guard | overvoltage_guard | overtemp_guard | offset_guard
                           | (|overcurrent_guard) | (|window_guard);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            busy_cnt <= 32'h0;
        else if (clk_en)
            busy_cnt <= detect_busy ? busy_cnt + 32'h1 : 32'h0;
    end
    default clocking @(posedge sys_clk); endclocking
    // Frozen cycles are excluded, since clk_en low stops every register.
    default disable iff (!arst_n || !clk_en);
    sequence s_no_short;
        (overcurrent_guard == 2'h0 && window_guard == 2'h0)[*5];
    endsequence
    sequence s_uv_in_det;
        (undervoltage_guard && detect_busy) ##1 undervoltage_guard[*4];
    endsequence
    sequence s_ramp_done;
        $fell(ramp_discharge) ##0 master_mode;
    endsequence
    // ==========
    // Assertions
    a_pins_open_drain: assert property (!fault_report_pin_o && !saturation_flag_pin_o)
        else $error("flag pin driven high");
    a_short_pulls_fault: assert property ((overcurrent_guard != 2'h0 || window_guard != 2'h0)[*4] |-> fault_report_pin_oe)
        else $error("short without fault pin");
    a_fault_release: assert property ((!any_fault)[*5] |-> !fault_report_pin_oe)
        else $error("fault pin held after fault gone");
    a_short_latched: assert property (result_byte_one[3] && !result_read |=> result_byte_one[3])
        else $error("short bit lost without read");
    a_read_clears: assert property (s_no_short ##0 result_read |=> !result_byte_one[3] && !result_byte_two[3])
        else $error("read did not clear short bits");
    a_detect_quiet: assert property (detect_busy |-> !switching_en)
        else $error("switching during detection");
    a_detect_length: assert property (detect_busy |-> busy_cnt <= DET_CYCLES + 2)
        else $error("detection runs too long");
    a_mute_before_ramp: assert property (ramp_discharge |-> mute_req)
        else $error("ramp discharged while unmuted");
    a_master_hold: assert property (s_ramp_done |=> osc_run[*7])
        else $error("master clock stopped early");
    a_valid_abort: assert property (s_uv_in_det |-> !result_byte_one[6])
        else $error("valid bit kept after supply fault");
    a_clip_host: assert property ((host_mode && !instr_byte_one[5] && clip_detect[0])[*6] |-> saturation_flag_pin_oe)
        else $error("clip not flagged");
endmodule
bind adr_fault_report_pin adr_fault_report_pin_props #(.DET_CYCLES(DET_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) i_props (.sys_clk, .arst_n,
    .clk_en, .host_mode, .master_mode, .result_read, .por_event, .undervoltage_guard, .overvoltage_guard,
    .overtemp_guard, .offset_guard, .overcurrent_guard, .window_guard, .clip_detect, .instr_byte_one,
    .result_byte_one, .result_byte_two, .fault_report_pin_o, .fault_report_pin_oe, .saturation_flag_pin_o,
    .saturation_flag_pin_oe, .detect_busy, .switching_en, .mute_req, .ramp_discharge, .osc_run);
`default_nettype wire

// file: dv/adr_host_model.sv
// Host controller and pull-up model on the far side of the diagnostic block.
`timescale 1ns/1ps
`default_nettype none
module adr_host_model #(
    parameter integer RETRY_LIMIT = 3
) (
    input  wire logic       sys_clk,
    input  wire logic       start,
    input  wire logic       detect_busy,
    input  wire logic       fault_report_pin_oe,
    input  wire logic       saturation_flag_pin_oe,
    input  wire logic [7:0] ib2_base,
    input  wire logic [7:0] result_byte_one,
    output logic      [7:0] instr_byte_two,
    output logic            fault_report_pin,
    output logic            saturation_flag_pin,
    output logic            det_done
);
    logic det_en;
    // ==========
    // Pull-ups: a released line rises rather than keeping its last level.
    assign fault_report_pin    = fault_report_pin_oe ? 1'h0 : 1'h1;
    assign saturation_flag_pin = saturation_flag_pin_oe ? 1'h0 : 1'h1;
    assign instr_byte_two      = {ib2_base[7:3], det_en, ib2_base[1:0]};
    // ==========
    // Detection loop, bounded so a dead load cannot stall start-up forever.
    initial begin
        int tries;
        int w;
        det_en = 1'h0;
        det_done = 1'h0;
        wait (start);
        for (tries = 0; tries < RETRY_LIMIT && !det_done; tries++) begin
            @(negedge sys_clk) det_en = 1'h1;
            for (w = 0; w < 200 && (w < 10 || detect_busy); w++)
                @(negedge sys_clk);
            det_en = 1'h0;
            repeat (4) @(negedge sys_clk);
            det_done = result_byte_one[6];
        end
        det_done = 1'h1;
    end
endmodule
`default_nettype wire

// file: dv/tb_amp_diagnostic_reporting.sv
// Self-checking bench for the amplifier diagnostic reporting block.
`timescale 1ns/1ps
`default_nettype none
module tb_amp_diagnostic_reporting;
    logic            sys_clk, arst_n, clk_en, host_mode, master_mode, result_read, power_up_pin, start;
    logic            offset_guard, temp_warning, ac_current_over, ramp_discharged, amp_hang;
    logic      [7:0] src, instr_byte_one, ib2_base, instr_byte_three, b1, b2;
    logic      [1:0] clip_detect, open_load_sense;
    wire logic       por_event, undervoltage_guard, overvoltage_guard, overtemp_guard;
    wire logic [1:0] overcurrent_guard, window_guard;
    wire logic [7:0] instr_byte_two, result_byte_one, result_byte_two;
    wire logic       fault_report_pin_o, fault_report_pin_oe, saturation_flag_pin_o, saturation_flag_pin_oe;
    wire logic       detect_busy, switching_en, mute_req, ramp_discharge, osc_run;
    wire logic       fault_report_pin, saturation_flag_pin, det_done;
    logic     [16:0] notes[$];
    int              fail_count = 0, comparisons = 0, cycles = 0;
    assign {por_event, overvoltage_guard, overtemp_guard, overcurrent_guard, window_guard, undervoltage_guard} = src;
    adr_fault_report_pin #(.DET_CYCLES(20), .HOLD_CYCLES(40)) i_dut (.sys_clk, .arst_n, .clk_en, .host_mode, .master_mode,
        .instr_byte_one, .instr_byte_two, .instr_byte_three, .result_read, .power_up_pin, .por_event,
        .undervoltage_guard, .overvoltage_guard, .overcurrent_guard, .window_guard, .overtemp_guard,
        .offset_guard, .clip_detect, .temp_warning, .ac_current_over, .open_load_sense, .ramp_discharged,
        .amp_hang, .result_byte_one, .result_byte_two, .fault_report_pin_o, .fault_report_pin_oe,
        .saturation_flag_pin_o, .saturation_flag_pin_oe, .detect_busy, .switching_en, .mute_req,
        .ramp_discharge, .osc_run);
    adr_host_model i_host (.sys_clk, .start, .detect_busy, .fault_report_pin_oe, .saturation_flag_pin_oe,
        .ib2_base, .result_byte_one, .instr_byte_two, .fault_report_pin, .saturation_flag_pin, .det_done);
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ==========
    // Tasks
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic exp_pins(input logic [1:0] v);
        notes.push_back({1'h1, 14'h0, v});
        step(1);
    endtask
    task automatic exp_bytes(input logic [7:0] x1, input logic [7:0] x2);
        notes.push_back({1'h0, x1, x2});
        step(1);
    endtask
    task automatic rd(input logic [7:0] a1, a2, c1, c2);
        exp_bytes(a1, a2);
        result_read = 1'h1;
        step(1);
        result_read = 1'h0;
        step(1);
        exp_bytes(c1, c2);
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // The watcher samples at the rising edge, before that edge's updates land.
    always @(posedge sys_clk) begin
        logic [16:0] e;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
        if (notes.size() != 0) begin
            e = notes.pop_front();
            if (e[16])
                cmp({14'h0, fault_report_pin, saturation_flag_pin}, e[15:0]);
            else
                cmp({result_byte_one, result_byte_two}, e[15:0]);
        end
    end
    // ==========
    // Main sequence
    initial begin
        int i;
        logic [3:0] r;
        void'($urandom(32'h08896920));
        {clk_en, host_mode, master_mode, result_read, power_up_pin, start} = 6'h30;
        {offset_guard, temp_warning, ac_current_over, ramp_discharged, amp_hang} = 5'h0;
        src = 8'h0;
        clip_detect = 2'h0;
        open_load_sense = 2'($urandom);
        instr_byte_one = 8'h03;
        ib2_base = 8'h03;
        instr_byte_three = 8'h00;
        arst_n = 1'h0;
        step(10);
        arst_n = 1'h1;
        step(2);
        exp_bytes(8'h00, 8'h00);
        for (i = 0; i < 8; i++) begin
            src = 8'(8'h01 << i);
            step(6);
            exp_pins({1'h0, i != 7});
            src = 8'h0;
            step(6);
            exp_pins(2'h3);
        end
        power_up_pin = 1'h1;
        start = 1'h1;
        wait (detect_busy);
        step(5);
        src = 8'h01;
        step(6);
        src = 8'h00;
        wait (det_done);
        step(1);
        b1 = {3'h2, open_load_sense[0], 4'h0};
        b2 = {3'h0, open_load_sense[1], 4'h0};
        exp_bytes(b1, b2);
        instr_byte_one = 8'h01;
        ib2_base = 8'h00;
        step(40);
        src = 8'h18;
        step(6);
        exp_pins(2'h1);
        src = 8'h00;
        step(6);
        rd(b1 | 8'h08, b2 | 8'h08, b1, b2);
        src = 8'h10;
        step(6);
        rd(b1, b2 | 8'h08, b1, b2 | 8'h08);
        src = 8'h00;
        step(6);
        rd(b1, b2 | 8'h08, b1, b2);
        for (i = 0; i < 2; i++) begin
            instr_byte_one = {i[0], 7'h01};
            offset_guard = 1'h1;
            step(6);
            exp_pins({i[0], 1'h1});
            offset_guard = 1'h0;
            step(6);
            rd(b1 | 8'h04, b2, b1, b2);
        end
        for (i = 0; i < 16; i++) begin
            r = 4'($urandom);
            {instr_byte_three[4], ib2_base[4], ib2_base[5], instr_byte_one[5]} = i[3:0];
            {ac_current_over, temp_warning, clip_detect} = r;
            step(6);
            exp_pins({1'h1, !((r[0] & !i[0]) | (r[1] & !i[1]) | (r[2] & !i[2]) | (r[3] & i[3]))});
        end
        host_mode = 1'h0;
        {instr_byte_one, ib2_base, instr_byte_three} = 24'ha13000;
        {offset_guard, temp_warning, ac_current_over, clip_detect} = 5'h1b;
        step(8);
        exp_pins(2'h0);
        {offset_guard, temp_warning, clip_detect} = 4'h0;
        step(8);
        exp_pins(2'h3);
        master_mode = 1'h1;
        power_up_pin = 1'h0;
        wait (ramp_discharge);
        step(10);
        ramp_discharged = 1'h1;
        step(60);
        conclude();
    end
endmodule
`default_nettype wire
